// ---- port_activity_monitor.sv ----
/*
 * Port activity monitor: eight chip-select watchers with programmable edge
 * polarity, optional host strobe qualification, sticky flags and a
 * maskable interrupt toward the core.
 * Assumes the core drives an 8-bit SFR request each cycle, supplies the
 * global interrupt enable and priority bits from its own registers, and
 * reads the port input path through port_level_out.
 */
`timescale 1ns/100ps
`default_nettype none

module port_activity_monitor (
   input  wire logic                    clock_in,
   input  wire logic                    rst_n_in,
   // SFR bus
   input  wire monitor_pkg::sfr_req_t   sfr_req_in,
   output monitor_pkg::sfr_rsp_t        sfr_rsp_out,
   // Monitored port lines and host strobes
   input  wire logic [7:0]              port_pin_in,
   input  wire monitor_pkg::host_strobe_t host_strobe_n_in,
   // Core interrupt controls
   input  wire logic                    monitor_irq_enable_in,
   input  wire logic                    monitor_irq_priority_in,
   // Outputs
   output logic      [7:0]              port_level_out,
   output logic      [7:0]              activity_pulse_out,
   output logic                         monitor_irq_out,
   output logic                         monitor_irq_high_out
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int SAMPLED = monitor_pkg::LINES + monitor_pkg::STROBES;
   localparam logic [SAMPLED-1:0] SAMPLE_IDLE =
      {monitor_pkg::IDLE_STROBES, monitor_pkg::IDLE_LINES};

   logic [7:0]         monitor_enable_q;
   logic [7:0]         monitor_qualifier_q;
   logic [7:0]         monitor_polarity_q;
   logic [7:0]         monitor_flags_q;
   logic [7:0]         monitor_flags_d;

   logic [SAMPLED-1:0] sample_raw;
   logic [SAMPLED-1:0] sample_level;
   logic [SAMPLED-1:0] sample_prev;

   logic [7:0]         line_level;
   logic [7:0]         line_prev;
   logic               host_read_strobe_n;
   logic               host_write_strobe_n;
   logic               strobe_valid;

   logic [7:0]         rise;
   logic [7:0]         fall;
   logic [7:0]         active_edge;
   logic [7:0]         qualified_edge;
   logic [7:0]         flag_set;
   logic [7:0]         flag_clear;

   logic               wr_enable;
   logic               wr_qualifier;
   logic               wr_polarity;
   logic               wr_flags;

   logic               read_hit;
   logic [7:0]         read_data;

   monitor_pkg::sfr_rsp_t sfr_rsp_q;
   logic [7:0]         port_level_q;
   logic [7:0]         activity_pulse_q;
   logic               monitor_irq_q;
   logic               monitor_irq_high_q;

   // ----------------------------------------------------------------
   // Input sampling
   // ----------------------------------------------------------------
   // Strobes share the sampler so they stay aligned with the lines.
   assign sample_raw = {host_strobe_n_in.read_n,
                        host_strobe_n_in.write_n,
                        port_pin_in};

   line_sampler #(
      .WIDTH      (SAMPLED),
      .IDLE_VALUE (SAMPLE_IDLE)
   ) u_sampler (
      .clock_in  (clock_in),
      .rst_n_in  (rst_n_in),
      .raw_in    (sample_raw),
      .level_out (sample_level),
      .prev_out  (sample_prev)
   );

   assign line_level          = sample_level[monitor_pkg::LINES-1:0];
   assign line_prev           = sample_prev[monitor_pkg::LINES-1:0];
   assign host_write_strobe_n = sample_level[monitor_pkg::LINES];
   assign host_read_strobe_n  = sample_level[monitor_pkg::LINES+1];

   // Either active-low strobe low counts as a valid host cycle
   assign strobe_valid = ~host_read_strobe_n | ~host_write_strobe_n;

   // ----------------------------------------------------------------
   // Per-line edge detection and qualification
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < monitor_pkg::LINES; g++) begin : g_line
         assign rise[g] = line_level[g] & ~line_prev[g];
         assign fall[g] = ~line_level[g] & line_prev[g];

         // Zero picks the falling edge, one the rising edge
         assign active_edge[g] = monitor_polarity_q[g] ? rise[g] : fall[g];

         // Qualifier off lets any active edge through
         assign qualified_edge[g] = active_edge[g] &
                                    (~monitor_qualifier_q[g] | strobe_valid);

         // Disabled lines never touch their flag
         assign flag_set[g] = qualified_edge[g] & monitor_enable_q[g];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   assign wr_enable    = sfr_req_in.wr & (sfr_req_in.addr == monitor_pkg::ADDR_ENABLE);
   assign wr_qualifier = sfr_req_in.wr & (sfr_req_in.addr == monitor_pkg::ADDR_QUALIFIER);
   assign wr_polarity  = sfr_req_in.wr & (sfr_req_in.addr == monitor_pkg::ADDR_POLARITY);
   assign wr_flags     = sfr_req_in.wr & (sfr_req_in.addr == monitor_pkg::ADDR_FLAGS);

   // Zeros in the written byte clear, ones are ignored
   assign flag_clear = wr_flags ? ~sfr_req_in.wdata : 8'h00;

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         monitor_enable_q <= monitor_pkg::RESET_ENABLE;
      end else if (wr_enable) begin
         monitor_enable_q <= sfr_req_in.wdata;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         monitor_qualifier_q <= monitor_pkg::RESET_QUALIFIER;
      end else if (wr_qualifier) begin
         monitor_qualifier_q <= sfr_req_in.wdata;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         monitor_polarity_q <= monitor_pkg::RESET_POLARITY;
      end else if (wr_polarity) begin
         monitor_polarity_q <= sfr_req_in.wdata;
      end
   end

   // ----------------------------------------------------------------
   // Activity flags
   // ----------------------------------------------------------------
   // Set term is applied after the clear so a same-cycle edge survives.
   always_comb begin
      monitor_flags_d = (monitor_flags_q & ~flag_clear) | flag_set;
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         monitor_flags_q <= monitor_pkg::RESET_FLAGS;
      end else begin
         monitor_flags_q <= monitor_flags_d;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt request
   // ----------------------------------------------------------------
   // Level request: stays up until firmware clears the flag or the enable.
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         monitor_irq_q      <= 1'b0;
         monitor_irq_high_q <= 1'b0;
      end else begin
         monitor_irq_q      <= monitor_irq_enable_in &
                               (|(monitor_flags_q & monitor_enable_q));
         monitor_irq_high_q <= monitor_irq_priority_in;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      read_hit  = 1'b1;
      read_data = monitor_pkg::READ_UNMAPPED;
      case (sfr_req_in.addr)
         monitor_pkg::ADDR_ENABLE: begin
            read_data = monitor_enable_q;
         end
         monitor_pkg::ADDR_QUALIFIER: begin
            read_data = monitor_qualifier_q;
         end
         monitor_pkg::ADDR_POLARITY: begin
            read_data = monitor_polarity_q;
         end
         monitor_pkg::ADDR_FLAGS: begin
            read_data = monitor_flags_q;
         end
         default: begin
            read_hit  = 1'b0;
            read_data = monitor_pkg::READ_UNMAPPED;
         end
      endcase
   end

   // Answer appears the cycle after the read strobe and holds until the next
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sfr_rsp_q <= '0;
      end else if (sfr_req_in.rd) begin
         sfr_rsp_q.read_hit <= read_hit;
         sfr_rsp_q.rdata    <= read_data;
      end
   end

   // ----------------------------------------------------------------
   // Port level and activity observation
   // ----------------------------------------------------------------
   // Pin levels pass regardless of enable so the port input path works.
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         port_level_q <= monitor_pkg::IDLE_LINES;
      end else begin
         port_level_q <= line_level;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         activity_pulse_q <= 8'h00;
      end else begin
         activity_pulse_q <= flag_set;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign sfr_rsp_out          = sfr_rsp_q;
   assign port_level_out       = port_level_q;
   assign activity_pulse_out   = activity_pulse_q;
   assign monitor_irq_out      = monitor_irq_q;
   assign monitor_irq_high_out = monitor_irq_high_q;

endmodule : port_activity_monitor

`default_nettype wire

// ---- monitor_pkg.sv ----
/*
 * Constants, register map and carrier types for the port activity monitor.
 * Assumes an 8-bit special-function-register bus from the core and eight
 * monitor lines on one parallel port.
 */
// Notes on behaviour
// - Each monitor-enable bit selects its port line as a monitor input.
// - Port line levels stay readable always, whatever the enable bits hold.
// - Polarity zero selects falling edge (default); polarity one selects rising edge.
// - An active edge on an enabled line sets that line's flag bit.
// - Qualifier one: edge counts only with a host read or write strobe.
// - Qualifier zero (default): any active edge on that line counts.
// - Monitor interrupt gated by global enable; priority from matching priority bit.
// - With interrupts enabled, an active edge raises an interrupt; firmware reads flags.
// - Writing zero clears a flag bit; writing one leaves it unchanged.
// - Interrupt condition exists while a flag bit and its enable bit are set.
// - Qualifier, polarity and flag registers reset to all zeros.

package monitor_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int LINES = 8;
   localparam int STROBES = 2;

   // ----------------------------------------------------------------
   // Register offsets on the SFR bus
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_ENABLE    = 8'h92;
   localparam logic [7:0] ADDR_QUALIFIER = 8'h93;
   localparam logic [7:0] ADDR_POLARITY  = 8'h94;
   localparam logic [7:0] ADDR_FLAGS     = 8'h95;

   // ----------------------------------------------------------------
   // Reset values and unmapped read value
   // ----------------------------------------------------------------
   localparam logic [7:0] RESET_ENABLE    = 8'h00;
   localparam logic [7:0] RESET_QUALIFIER = 8'h00;
   localparam logic [7:0] RESET_POLARITY  = 8'h00;
   localparam logic [7:0] RESET_FLAGS     = 8'h00;
   localparam logic [7:0] READ_UNMAPPED   = 8'h00;

   // Idle level of chip selects and active-low strobes
   localparam logic [7:0] IDLE_LINES   = 8'hff;
   localparam logic [1:0] IDLE_STROBES = 2'h3;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sfr_req_t;

   typedef struct packed {
      logic       read_hit;
      logic [7:0] rdata;
   } sfr_rsp_t;

   typedef struct packed {
      logic read_n;
      logic write_n;
   } host_strobe_t;

endpackage : monitor_pkg

// ---- line_sampler.sv ----
/*
 * Synchroniser for the monitor lines and host strobes, with one extra
 * stage holding the previous sample for edge detection.
 * Assumes inputs asynchronous to clock_in; reset is synchronous, active low.
 */
`timescale 1ns/100ps
`default_nettype none

module line_sampler #(
   parameter int                 WIDTH      = 10,
   parameter logic [WIDTH-1:0]   IDLE_VALUE = '1
) (
   input  wire logic             clock_in,
   input  wire logic             rst_n_in,
   input  wire logic [WIDTH-1:0] raw_in,
   output logic      [WIDTH-1:0] level_out,
   output logic      [WIDTH-1:0] prev_out
);

   // ----------------------------------------------------------------
   // Two-flop synchroniser plus history stage
   // ----------------------------------------------------------------
   // First stage feeds only the second; idle reset avoids a false edge.
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         meta_q    <= IDLE_VALUE;
         level_out <= IDLE_VALUE;
         prev_out  <= IDLE_VALUE;
      end else begin
         meta_q    <= raw_in;
         level_out <= meta_q;
         prev_out  <= level_out;
      end
   end

endmodule : line_sampler

`default_nettype wire

// ---- host_bus_model.sv ----
/* Host side model: chip-select lines and host I/O strobes.
   Assumes the bench sets the requests at the falling edge of the clock. */
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
   input  wire logic [7:0]           cs_req_in,
   input  wire logic [1:0]           strobe_req_in,
   output logic      [7:0]           cs_n_out,
   output monitor_pkg::host_strobe_t strobe_n_out
);
   // Selects idle high and fall only while requested
   // Unrequested lines are driven high, as the port latch one must allow
   assign cs_n_out     = ~cs_req_in;
   assign strobe_n_out = ~strobe_req_in;
endmodule : host_bus_model
`default_nettype wire

// ---- port_activity_monitor_sva.sv ----
/* Checker for the port activity monitor, bound to its top module.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module monitor_checker (
   input wire logic                      clock_in,
   input wire logic                      rst_n_in,
   input wire monitor_pkg::sfr_req_t     sfr_req_in,
   input wire monitor_pkg::sfr_rsp_t     sfr_rsp_out,
   input wire logic [7:0]                port_pin_in,
   input wire monitor_pkg::host_strobe_t host_strobe_n_in,
   input wire logic                      monitor_irq_enable_in,
   input wire logic                      monitor_irq_priority_in,
   input wire logic [7:0]                port_level_out,
   input wire logic [7:0]                activity_pulse_out,
   input wire logic                      monitor_irq_out,
   input wire logic                      monitor_irq_high_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   logic mapped;
   logic flag_wr;
   assign mapped  = sfr_req_in.addr >= 8'h92 && sfr_req_in.addr <= 8'h95;
   assign flag_wr = sfr_req_in.wr && sfr_req_in.addr == monitor_pkg::ADDR_FLAGS;
   a_read_decode: assert property (sfr_req_in.rd |=> sfr_rsp_out.read_hit == $past(mapped))
      else $error("read hit flag wrong");
   a_unmapped_zero: assert property (sfr_req_in.rd && !mapped |=> sfr_rsp_out.rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rsp_holds: assert property (!sfr_req_in.rd |=> $stable(sfr_rsp_out))
      else $error("read response moved without a read");
   a_level_sync: assert property ($past(rst_n_in) && $past(rst_n_in, 2) &&
      $past(rst_n_in, 3) |-> port_level_out == $past(port_pin_in, 3))
      else $error("port level not three cycles behind pin");
   a_prio_copy: assert property ($past(rst_n_in) |->
      monitor_irq_high_out == $past(monitor_irq_priority_in)) else $error("priority copy wrong");
   a_irq_gate: assert property (!monitor_irq_enable_in |=> !monitor_irq_out)
      else $error("interrupt raised while globally disabled");
   a_pulse_single: assert property ((activity_pulse_out & $past(activity_pulse_out)) == 8'h00)
      else $error("activity pulse longer than one cycle");
   a_pulse_cause: assert property ((activity_pulse_out &
      ~(port_level_out ^ $past(port_level_out))) == 8'h00)
      else $error("activity pulse without a level change");
   a_irq_on_pulse: assert property (activity_pulse_out != 8'h00 &&
      monitor_irq_enable_in |=> monitor_irq_out) else $error("pulse without interrupt");
   a_flag_read: assert property (sfr_req_in.rd && sfr_req_in.addr == 8'h95 && !$past(flag_wr) |=>
      (sfr_rsp_out.rdata & $past(activity_pulse_out)) == $past(activity_pulse_out))
      else $error("flag missing after pulse");
   c_pulse: cover property (activity_pulse_out != 8'h00);
   c_irq: cover property ($rose(monitor_irq_out));
   c_unmapped: cover property (sfr_req_in.rd && !mapped);
   c_strobed: cover property (host_strobe_n_in != 2'h3 && activity_pulse_out != 8'h00);
endmodule : monitor_checker
bind port_activity_monitor monitor_checker u_chk (.clock_in, .rst_n_in, .sfr_req_in,
   .sfr_rsp_out, .port_pin_in, .host_strobe_n_in, .monitor_irq_enable_in,
   .monitor_irq_priority_in, .port_level_out, .activity_pulse_out, .monitor_irq_out,
   .monitor_irq_high_out);
`default_nettype wire

// ---- test_port_activity_monitor.sv ----
/* Self-checking bench for the port activity monitor.
   Assumes the host model and the bound checker are compiled with it. */
`timescale 1ns/100ps
`default_nettype none
module test_port_activity_monitor;
   logic                      clock_in    = 1'b0;
   logic                      rst_n_in    = 1'b0;
   monitor_pkg::sfr_req_t     sfr_req_in  = '0;
   monitor_pkg::sfr_rsp_t     sfr_rsp_out;
   monitor_pkg::host_strobe_t strobe_n;
   logic [7:0]                cs_req      = 8'h00;
   logic [1:0]                strobe_req  = 2'h0;
   logic                      irq_en      = 1'b0;
   logic                      irq_pri     = 1'b0;
   logic [7:0]                pin, level, pulse;
   logic                      irq, irq_high;
   int                        error_cnt   = 0;
   int                        comparisons = 0;
   int                        cycles      = 0;
   // Line request, strobe request, flags expected after the step
   logic [7:0] cs_tab [8] = '{8'h03, 8'h07, 8'h03, 8'h0b, 8'h03, 8'h0b, 8'h13, 8'h33};
   logic [1:0] st_tab [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0};
   logic [7:0] fl_tab [8] = '{8'h01, 8'h01, 8'h05, 8'h05, 8'h05, 8'h0d, 8'h1d, 8'h3d};
   always #10 clock_in = ~clock_in;
   host_bus_model HOST (.cs_req_in(cs_req), .strobe_req_in(strobe_req), .cs_n_out(pin),
      .strobe_n_out(strobe_n));
   port_activity_monitor DUT (.clock_in, .rst_n_in, .sfr_req_in, .sfr_rsp_out,
      .port_pin_in(pin), .host_strobe_n_in(strobe_n), .monitor_irq_enable_in(irq_en),
      .monitor_irq_priority_in(irq_pri), .port_level_out(level), .activity_pulse_out(pulse),
      .monitor_irq_out(irq), .monitor_irq_high_out(irq_high));
   task automatic conclude;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check8
   // One request per cycle; the next call overwrites it at the following falling edge
   task automatic sfr_op(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
      sfr_req_in = '{addr: a, wdata: d, wr: w, rd: r};
      @(negedge clock_in);
   endtask : sfr_op
   task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
      sfr_op(a, 8'h00, 1'b0, 1'b1);
      check8("rdata", exp, sfr_rsp_out.rdata);
      check8("read_hit", {7'h00, a >= 8'h92 && a <= 8'h95}, {7'h00, sfr_rsp_out.read_hit});
   endtask : sfr_rd
   task automatic idle(input int n);
      sfr_req_in = '0;
      repeat (n) @(negedge clock_in);
   endtask : idle
   always @(posedge clock_in) begin
      cycles++;
      if (cycles > 2000) begin
         error_cnt++;
         conclude();
      end
   end
   initial begin
      repeat (5) @(negedge clock_in);
      rst_n_in = 1'b1;
      for (int i = 0; i < 5; i++) sfr_rd(8'(8'h92 + i), 8'h00);
      for (int i = 0; i < 3; i++) begin
         sfr_op(8'(8'h92 + i), 8'ha5 ^ 8'(i), 1'b1, 1'b0);
         sfr_rd(8'(8'h92 + i), 8'ha5 ^ 8'(i));
      end
      sfr_op(8'h95, 8'hff, 1'b1, 1'b0);
      sfr_rd(8'h95, 8'h00);
      sfr_op(8'h92, 8'h3d, 1'b1, 1'b0);
      sfr_op(8'h93, 8'h18, 1'b1, 1'b0);
      sfr_op(8'h94, 8'h04, 1'b1, 1'b0);
      irq_en = 1'b1;
      for (int s = 0; s < 8; s++) begin
         cs_req = cs_tab[s];
         strobe_req = st_tab[s];
         idle(4);
         check8("port level", ~cs_tab[s], level);
         check8("irq", 8'h01, {7'h00, irq});
         sfr_rd(8'h95, fl_tab[s]);
      end
      strobe_req = 2'h0;
      sfr_op(8'h95, 8'hfe, 1'b1, 1'b0);
      sfr_op(8'h92, 8'h01, 1'b1, 1'b0);
      idle(2);
      check8("irq", 8'h00, {7'h00, irq});
      sfr_rd(8'h95, 8'h3c);
      sfr_op(8'h92, 8'h3d, 1'b1, 1'b0);
      idle(2);
      check8("irq", 8'h01, {7'h00, irq});
      irq_en = 1'b0;
      irq_pri = 1'b1;
      cs_req = 8'h32;
      idle(2);
      cs_req = 8'h33;
      idle(4);
      check8("irq", 8'h00, {7'h00, irq});
      check8("irq high", 8'h01, {7'h00, irq_high});
      sfr_rd(8'h95, 8'h3d);
      // Clearing write lands on the edge that sets flag 0
      cs_req = 8'h32;
      idle(2);
      cs_req = 8'h33;
      idle(2);
      sfr_op(8'h95, 8'h00, 1'b1, 1'b0);
      check8("pulse", 8'h01, pulse);
      sfr_rd(8'h95, 8'h01);
      rst_n_in = 1'b0;
      idle(5);
      rst_n_in = 1'b1;
      for (int i = 0; i < 4; i++) sfr_rd(8'(8'h92 + i), 8'h00);
      check8("port level", 8'hcc, level);
      conclude();
   end
endmodule : test_port_activity_monitor
`default_nettype wire
